// ---- edm_pkg.sv ----
/*
  Constants, register map and carrier types of the encoder feedback and
  deviation monitor. Assumes a 25 MHz system clock and an APB master.
*/
// Notes on behaviour
// - Switch query returns left limit, right limit and homing input levels as 0/1.
// - Nonzero pre-divider N passes only every Nth encoder pulse to the count.
// - Nonzero multiplier M changes the count by M per passed pulse, up or down; zero changes it by 1.
// - Configuration bit 0 picks index polarity: 1 active high, 0 active low.
// - While configuration bit 1 is set, next active index edge clears the count.
// - Writing configuration bit 4 loads ramp position into count; bit then self-clears.
// - Configuration bit 6 picks reference phase order: 1 A leads B, 0 B leads A.
// - Deviation limit is an 11-bit unsigned value.
// - Count reads back as a signed 24-bit value.
// - Enabled deviation alarm beyond the limit drives the alarm output high.
// - Stop action on deviation: 0 keep moving, 1 soft stop, 2 hard stop.
// - Nonzero delay n starts correction n/200 s after deviation; zero disables it.
// - With correction after deviation, alarm waits until the retry limit is exceeded.
// - With correction on, check count at ramp end and move toward target otherwise.
// - Retry field 0 disables correction; exceeding 1..255 retries aborts and alarms.
// - Final position is correct within a 16-bit unsigned tolerance window.
// - Closed-loop enable: 0 switches the position loop off, 1 on.
// - Four setup words load the position loop configuration.
// - Position reset clears both ramp position and encoder count.
package edm_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_SCALE  = 8'h04;
  localparam logic [7:0] OFS_DEVLIM = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0c;
  localparam logic [7:0] OFS_ALARM  = 8'h10;
  localparam logic [7:0] OFS_CORR   = 8'h14;
  localparam logic [7:0] OFS_LOOP   = 8'h18;
  localparam logic [7:0] OFS_PID0   = 8'h1c;
  localparam logic [7:0] OFS_PID1   = 8'h20;
  localparam logic [7:0] OFS_PID2   = 8'h24;
  localparam logic [7:0] OFS_PID3   = 8'h28;
  localparam logic [7:0] OFS_SWITCH = 8'h2c;
  localparam logic [7:0] OFS_CMD    = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  // ==========================================================
  // Field positions
  localparam int CFG_NPOL  = 0;
  localparam int CFG_NCLR  = 1;
  localparam int CFG_LOAD  = 4;
  localparam int CFG_ABDIR = 6;
  localparam logic [7:0] CFG_WMASK = 8'h53;
  localparam int CMD_POSRST = 0;
  localparam int CNT_W  = 24;
  localparam int DEV_W  = 11;
  localparam int TOL_W  = 16;
  // ==========================================================
  // Reset values and timing
  localparam logic [7:0] CFG_RST = 8'h41;
  localparam logic [1:0] ACT_KEEP = 2'd0;
  localparam logic [1:0] ACT_SOFT = 2'd1;
  localparam logic [1:0] ACT_HARD = 2'd2;
  localparam int DELAY_UNIT_US = 5000;
  localparam int CLK_MHZ       = 25;
  localparam int TICK_CYC      = DELAY_UNIT_US * CLK_MHZ;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic left;
    logic right;
    logic home;
  } edm_sw_t;
  typedef struct packed {
    logic [15:0] control;
    logic [15:0] vcalc;
    logic [7:0]  pcof;
    logic [7:0]  prange;
    logic [7:0]  icof;
    logic [7:0]  irange;
    logic [7:0]  dcof;
    logic [7:0]  drange;
    logic [7:0]  clip_p;
    logic [7:0]  clip_i;
    logic [7:0]  clip_d;
    logic [7:0]  clip_int_sum;
    logic [7:0]  clip_int_in;
    logic [7:0]  pad;
    logic [15:0] clip_sum;
  } edm_pid_t;
  typedef enum {ST_IDLE, ST_WAIT, ST_CHECK, ST_MOVE} edm_state_t;
endpackage

// ---- edm_monitor.sv ----
/*
  Encoder feedback and deviation monitor with APB register access.
  Assumes synchronous encoder and switch inputs, a ramp generator that
  supplies ramp position, target, ramp-end and move-done pulses.
*/
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module edm_monitor #(
  parameter int TICK = edm_pkg::TICK_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  input  wire logic                    enc_a,
  input  wire logic                    enc_b,
  input  wire logic                    enc_n,
  input  wire edm_pkg::edm_sw_t        sw_in,
  input  wire logic [23:0]             ramp_pos,
  input  wire logic [23:0]             target_pos,
  input  wire logic                    ramp_end,
  input  wire logic                    move_done,
  output logic                         alarm_o,
  output logic                         soft_stop_o,
  output logic                         hard_stop_o,
  output logic                         pos_clear_o,
  output logic                         corr_move_o,
  output logic                         corr_up_o,
  output logic                         loop_en_o,
  output edm_pkg::edm_pid_t            pid_cfg_o
);
  import edm_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [23:0] mag_diff(input logic [23:0] a, input logic [23:0] b);
    logic [23:0] d;
    d = a - b;
    mag_diff = d[23] ? 24'(-d) : d;
  endfunction

  // {valid, forward} for A-leading order
  function automatic logic [1:0] quad(input logic [1:0] p, input logic [1:0] c);
    logic [3:0] t;
    t = {p, c};
    case (t)
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad = 2'b11;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad = 2'b10;
      default:                            quad = 2'b00;
    endcase
  endfunction

  // ==========================================================
  // Registers
  logic [7:0]       cfg_r;
  logic [7:0]       prediv_r;
  logic [7:0]       mult_r;
  logic [DEV_W-1:0] devlim_r;
  logic             dev_en_r;
  logic [1:0]       act_r;
  logic [15:0]      delay_r;
  logic [7:0]       retry_lim_r;
  logic [TOL_W-1:0] tol_r;
  logic             loop_en_r;
  logic [7:0]       clip_d_r;
  logic [127:0]     pid_r;
  logic [23:0]      count_r;
  logic             alarm_r;
  logic             dev_flag_r;
  logic             corr_err_r;

  logic wr;
  logic mapped;
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      OFS_CFG, OFS_SCALE, OFS_DEVLIM, OFS_COUNT, OFS_ALARM, OFS_CORR, OFS_LOOP,
      OFS_PID0, OFS_PID1, OFS_PID2, OFS_PID3, OFS_SWITCH, OFS_CMD,
      OFS_STATUS: mapped = 1'b1;
      default:    mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= CFG_RST;
    end else if (wr && paddr == OFS_CFG) begin
      cfg_r <= pwdata[7:0] & CFG_WMASK;
    end else begin
      cfg_r[CFG_LOAD] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prediv_r    <= 8'h00;
      mult_r      <= 8'h00;
      devlim_r    <= '0;
      dev_en_r    <= 1'b0;
      act_r       <= ACT_KEEP;
      delay_r     <= 16'h0000;
      retry_lim_r <= 8'h00;
      tol_r       <= '0;
      loop_en_r   <= 1'b0;
      clip_d_r    <= 8'h00;
      pid_r       <= '0;
    end else if (wr) begin
      case (paddr)
        OFS_SCALE: begin
          prediv_r <= pwdata[7:0];
          mult_r   <= pwdata[15:8];
        end
        OFS_DEVLIM: devlim_r <= pwdata[DEV_W-1:0];
        OFS_ALARM: begin
          dev_en_r <= pwdata[0];
          act_r    <= pwdata[2:1];
          delay_r  <= pwdata[31:16];
        end
        OFS_CORR: begin
          retry_lim_r <= pwdata[7:0];
          tol_r       <= pwdata[31:16];
        end
        OFS_LOOP: {clip_d_r, loop_en_r} <= {pwdata[15:8], pwdata[0]};
        OFS_PID0: pid_r[127:96] <= pwdata;
        OFS_PID1: pid_r[95:64]  <= pwdata;
        OFS_PID2: pid_r[63:32]  <= pwdata;
        OFS_PID3: pid_r[31:0]   <= pwdata;
        default: ;
      endcase
    end
  end
  assign loop_en_o = loop_en_r;
  // Derivative clip rides in the loop register, PID3 holds both sum clips
  assign pid_cfg_o = edm_pid_t'({pid_r[127:32], clip_d_r, pid_r[31:16], 8'h00, pid_r[15:0]});

  logic pos_rst;
  assign pos_rst = wr && paddr == OFS_CMD && pwdata[CMD_POSRST];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_clear_o <= 1'b0;
    end else begin
      pos_clear_o <= pos_rst;
    end
  end

  // ==========================================================
  // Quadrature decode, index, scaling
  logic [1:0] ab_r;
  logic       n_r;
  logic [7:0] div_r;
  logic [1:0] q;
  logic       step;
  logic       up;
  logic       n_act;
  logic       n_edge;
  logic       pass;
  logic [23:0] mag;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ab_r <= 2'b00;
      n_r  <= 1'b0;
    end else begin
      ab_r <= {enc_a, enc_b};
      n_r  <= n_act;
    end
  end
  assign q      = quad(ab_r, {enc_a, enc_b});
  assign step   = q[1];
  assign up     = q[0] ~^ cfg_r[CFG_ABDIR];
  assign n_act  = cfg_r[CFG_NPOL] ? enc_n : ~enc_n;
  assign n_edge = n_act & ~n_r;
  assign pass   = step && (prediv_r == 8'h00 || div_r == prediv_r - 8'h01);
  assign mag    = (mult_r == 8'h00) ? 24'h000001 : {16'h0000, mult_r};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 8'h00;
    end else if (pos_rst || prediv_r == 8'h00) begin
      div_r <= 8'h00;
    end else if (step) begin
      div_r <= pass ? 8'h00 : div_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= 24'h000000;
    end else if (pos_rst) begin
      count_r <= 24'h000000;
    end else if (cfg_r[CFG_LOAD]) begin
      count_r <= ramp_pos;
    end else if (cfg_r[CFG_NCLR] && n_edge) begin
      count_r <= 24'h000000;
    end else if (pass) begin
      count_r <= up ? count_r + mag : count_r - mag;
    end
  end

  // ==========================================================
  // Deviation detection and correction
  logic       dev_now;
  logic       dev_prev_r;
  logic       dev_evt;
  logic       in_tol;
  edm_state_t st_r;
  logic [16:0] tick_r;
  logic [15:0] units_r;
  logic [8:0]  tries_r;
  logic        abort;
  logic        alarm_set;

  assign dev_now = dev_en_r && mag_diff(ramp_pos, count_r) > {13'h0000, devlim_r};
  assign dev_evt = dev_now & ~dev_prev_r;
  assign in_tol  = mag_diff(target_pos, count_r) <= {8'h00, tol_r};
  assign abort   = st_r == ST_CHECK && !in_tol && tries_r >= {1'b0, retry_lim_r};
  assign alarm_set = (dev_evt && delay_r == 16'h0000) || abort;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dev_prev_r <= 1'b0;
    end else begin
      dev_prev_r <= dev_now;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r    <= ST_IDLE;
      tick_r  <= '0;
      units_r <= 16'h0000;
      tries_r <= 9'h000;
    end else begin
      case (st_r)
        ST_IDLE: begin
          tries_r <= 9'h000;
          tick_r  <= '0;
          units_r <= 16'h0000;
          if (dev_evt && delay_r != 16'h0000) begin
            st_r <= ST_WAIT;
          end else if (ramp_end && retry_lim_r != 8'h00) begin
            st_r <= ST_CHECK;
          end
        end
        ST_WAIT: begin
          if (tick_r == 17'(TICK - 1)) begin
            tick_r  <= '0;
            units_r <= units_r + 16'h0001;
            if (units_r + 16'h0001 == delay_r) begin
              st_r <= ST_CHECK;
            end
          end else begin
            tick_r <= tick_r + 17'h00001;
          end
        end
        ST_CHECK: begin
          if (in_tol || abort) begin
            st_r <= ST_IDLE;
          end else begin
            tries_r <= tries_r + 9'h001;
            st_r    <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (move_done) begin
            st_r <= ST_CHECK;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      corr_up_o <= 1'b0;
    end else if (st_r == ST_CHECK) begin
      corr_up_o <= $signed(target_pos) > $signed(count_r);
    end
  end
  assign corr_move_o = st_r == ST_MOVE;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_stop_o <= 1'b0;
      hard_stop_o <= 1'b0;
    end else begin
      soft_stop_o <= dev_evt && act_r == ACT_SOFT;
      hard_stop_o <= dev_evt && act_r == ACT_HARD;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_r    <= 1'b0;
      dev_flag_r <= 1'b0;
      corr_err_r <= 1'b0;
    end else begin
      if (alarm_set) begin
        alarm_r <= 1'b1;
      end else if (wr && paddr == OFS_STATUS && pwdata[0]) begin
        alarm_r <= 1'b0;
      end
      if (dev_evt) begin
        dev_flag_r <= 1'b1;
      end else if (wr && paddr == OFS_STATUS && pwdata[1]) begin
        dev_flag_r <= 1'b0;
      end
      if (abort) begin
        corr_err_r <= 1'b1;
      end else if (wr && paddr == OFS_STATUS && pwdata[2]) begin
        corr_err_r <= 1'b0;
      end
    end
  end
  assign alarm_o = alarm_r;

  // ==========================================================
  // Read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CFG:    prdata <= {24'h000000, cfg_r};
        OFS_SCALE:  prdata <= {16'h0000, mult_r, prediv_r};
        OFS_DEVLIM: prdata <= {21'h000000, devlim_r};
        OFS_COUNT:  prdata <= {8'h00, count_r};
        OFS_ALARM:  prdata <= {delay_r, 13'h0000, act_r, dev_en_r};
        OFS_CORR:   prdata <= {tol_r, 8'h00, retry_lim_r};
        OFS_LOOP:   prdata <= {16'h0000, clip_d_r, 7'h00, loop_en_r};
        OFS_PID0:   prdata <= pid_r[127:96];
        OFS_PID1:   prdata <= pid_r[95:64];
        OFS_PID2:   prdata <= pid_r[63:32];
        OFS_PID3:   prdata <= pid_r[31:0];
        OFS_SWITCH: prdata <= {29'h00000000, sw_in.home, sw_in.right, sw_in.left};
        OFS_STATUS: prdata <= {15'h0000, tries_r, 4'h0, corr_move_o, corr_err_r,
                               dev_flag_r, alarm_r};
        default:    prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  sw_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == OFS_SWITCH
    |=> prdata[2:0] == {$past(sw_in.home), $past(sw_in.right), $past(sw_in.left)})
    else $error("switch read mismatch");

  idx_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_r[CFG_NCLR] && n_edge && !pos_rst && !cfg_r[CFG_LOAD] |=> count_r == 24'h000000)
    else $error("index did not clear count");

  load_once_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_r[CFG_LOAD] && !(wr && paddr == OFS_CFG) && !pos_rst
    |=> !cfg_r[CFG_LOAD] && count_r == $past(ramp_pos))
    else $error("ramp load failed");

  mult_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    pass && up && mult_r != 8'h00 && !pos_rst && !cfg_r[CFG_LOAD]
    && !(cfg_r[CFG_NCLR] && n_edge)
    |=> count_r == $past(count_r) + {16'h0000, $past(mult_r)})
    else $error("multiplied step wrong");

  dev_alarm_a: assert property (@(posedge clk) disable iff (sys_rst)
    dev_evt && delay_r == 16'h0000 |=> alarm_o)
    else $error("deviation alarm missing");

  hard_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
    dev_evt && act_r == ACT_HARD |=> hard_stop_o && !soft_stop_o)
    else $error("hard stop missing");

  wait_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_r == ST_WAIT && !alarm_o && !dev_evt |=> !alarm_o)
    else $error("alarm during correction delay");

  retry_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_r == ST_CHECK && !in_tol && tries_r >= {1'b0, retry_lim_r}
    |=> alarm_o && corr_err_r && st_r == ST_IDLE)
    else $error("retry limit not enforced");

  pos_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    pos_rst |=> count_r == 24'h000000 && pos_clear_o ##1 !pos_clear_o)
    else $error("position reset failed");

  loop_en_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr && paddr == OFS_LOOP |=> loop_en_o == $past(pwdata[0]))
    else $error("loop enable not taken");
endmodule // edm_monitor
`default_nettype wire

// ---- edm_enc_model.sv ----
/*
  Quadrature encoder model standing at the far side of the monitor.
  Assumes one step request at a time, driven just after a rising clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module edm_enc_model (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic step,
  input  wire logic up,
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] phase_r;
  // ==========================================================
  // Gray phase walk, A leads B when moving up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= 2'h0;
    end else if (step) begin
      phase_r <= up ? phase_r + 2'h1 : phase_r - 2'h1;
    end
  end
  // One phase line changes per step, never both
  assign enc_a = phase_r[1] ^ phase_r[0];
  assign enc_b = phase_r[1];
endmodule  // edm_enc_model
`default_nettype wire

// ---- edm_monitor_bench.sv ----
/*
  Self-checking bench of the encoder feedback and deviation monitor.
  Assumes the monitor answers APB with zero wait states and a short TICK.
*/
`timescale 1ns/1ps
`default_nettype none
module edm_monitor_bench;
  import edm_pkg::*;
  localparam int TK = 4;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq, ex;
  logic        enc_a, enc_b, enc_n, step, up, ramp_end, move_done, move_q;
  logic        alarm_o, soft_stop_o, hard_stop_o, pos_clear_o;
  logic        corr_move_o, corr_up_o, loop_en_o;
  logic [23:0] ramp_pos, target_pos;
  logic [31:0] w [4];
  edm_sw_t     sw_in;
  edm_pid_t    pid_cfg_o;
  int          bad_count, total_checks, n_soft, n_hard, n_clr, n_move;
  int          m, n, k, lim, tol, t, s0, h0;

  edm_monitor #(.TICK(TK)) i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
    .sw_in(sw_in), .ramp_pos(ramp_pos), .target_pos(target_pos), .ramp_end(ramp_end),
    .move_done(move_done), .alarm_o(alarm_o), .soft_stop_o(soft_stop_o),
    .hard_stop_o(hard_stop_o), .pos_clear_o(pos_clear_o), .corr_move_o(corr_move_o),
    .corr_up_o(corr_up_o), .loop_en_o(loop_en_o), .pid_cfg_o(pid_cfg_o));
  edm_enc_model i_enc (.clk(clk), .sys_rst(sys_rst), .step(step), .up(up),
    .enc_a(enc_a), .enc_b(enc_b));

  // ==========================================================
  // Clock, pulse counters, watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    move_q <= corr_move_o;
    if (soft_stop_o === 1'b1) n_soft <= n_soft + 1;
    if (hard_stop_o === 1'b1) n_hard <= n_hard + 1;
    if (pos_clear_o === 1'b1) n_clr <= n_clr + 1;
    if (corr_move_o === 1'b1 && move_q !== 1'b1) n_move <= n_move + 1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string s);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, s, g, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int c;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (pready !== 1'b1 && c < 16);
    q = prdata;
    e = pslverr;
    chk({31'h0, pready}, 32'h1, "apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rq, re);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0, rq, re);
    chk(rq, x, s);
  endtask
  task automatic steps(input int c, input logic dir);
    repeat (c) begin
      step <= 1'b1;
      up <= dir;
      @(posedge clk);
      step <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse_end(input logic md);
    if (md) move_done <= 1'b1;
    else ramp_end <= 1'b1;
    @(posedge clk);
    move_done <= 1'b0;
    ramp_end <= 1'b0;
    @(posedge clk);
  endtask
  function automatic int scaled(int s, int dv, int ml);
    return (dv == 0 ? s : s / dv) * (ml == 0 ? 1 : ml);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; enc_n = 1'b0; step = 1'b0; up = 1'b0; ramp_end = 1'b0;
    move_done = 1'b0; sw_in = '0; ramp_pos = 24'h0; target_pos = 24'h0;
    void'($urandom(32'hb6549cdd));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(OFS_CFG, 32'h41, "cfg reset");
    wr(OFS_DEVLIM, 32'hffffffff);
    rd(OFS_DEVLIM, 32'h7ff, "limit width");
    apb(1'b0, 8'h3c, 32'h0, rq, re);
    chk({31'h0, re}, 32'h1, "unmapped");
    wr(OFS_COUNT, 32'h123);
    rd(OFS_COUNT, 32'h0, "count read only");
    for (int i = 0; i < 4; i++) begin
      sw_in <= edm_sw_t'(3'($urandom));
      repeat (3) @(posedge clk);
      rd(OFS_SWITCH, {29'h0, sw_in.home, sw_in.right, sw_in.left}, "switch");
    end
    $display("test registers and switches done");
    s0 = n_clr;
    for (int i = 0; i < 4; i++) begin
      m = $urandom_range(0, 255);
      k = $urandom_range(1, 20);
      wr(OFS_CMD, 32'h1);
      wr(OFS_SCALE, {16'h0, m[7:0], 8'h0});
      wr(OFS_CFG, {25'h0, i[0], 6'h01});
      steps(k, i[1]);
      ex = 32'(scaled(k, 0, m));
      if (i[0] != i[1]) ex = -ex;
      rd(OFS_COUNT, {8'h0, ex[23:0]}, "count");
    end
    chk(n_clr - s0, 32'd4, "position clear");
    $display("test multiplier and direction done");
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(OFS_COUNT, 32'h0, "count after reset");
    n = $urandom_range(2, 5);
    m = $urandom_range(1, 255);
    k = n * $urandom_range(1, 4) + n - 1;
    wr(OFS_SCALE, {16'h0, m[7:0], n[7:0]});
    steps(k, 1'b1);
    rd(OFS_COUNT, 32'(scaled(k, n, m)), "divider");
    $display("test divider done");
    wr(OFS_SCALE, 32'h0);
    ramp_pos <= 24'($urandom);
    wr(OFS_CFG, 32'h51);
    rd(OFS_CFG, 32'h41, "load self clear");
    rd(OFS_COUNT, {8'h0, ramp_pos}, "load");
    for (int p = 0; p < 2; p++) begin
      enc_n <= ~p[0];
      wr(OFS_CFG, 32'h42 | p);
      steps(3, 1'b1);
      enc_n <= p[0];
      repeat (3) @(posedge clk);
      enc_n <= ~p[0];
      repeat (3) @(posedge clk);
      rd(OFS_COUNT, 32'h0, "index clear");
    end
    $display("test load and index done");
    for (int i = 0; i < 2; i++) begin
      k = $urandom_range(0, 255);
      wr(OFS_LOOP, {16'h0, k[7:0], 7'h0, 1'(1 - i)});
      chk({31'h0, loop_en_o}, 32'(1 - i), "loop enable");
      chk({24'h0, pid_cfg_o.clip_d}, 32'(k), "clip d");
    end
    for (int i = 0; i < 4; i++) begin
      w[i] = $urandom;
      wr(OFS_PID0 + 8'(4 * i), w[i]);
    end
    for (int i = 0; i < 3; i++) chk(pid_cfg_o[143 - 32 * i -: 32], w[i], "pid");
    chk({pid_cfg_o[39:24], pid_cfg_o[15:0]}, w[3], "pid3");
    $display("test loop setup done");
    ramp_pos <= 24'h0;
    wr(OFS_CMD, 32'h1);
    wr(OFS_CORR, 32'h0);
    lim = $urandom_range(1, 2047);
    wr(OFS_DEVLIM, 32'(lim));
    for (int i = 0; i < 4; i++) begin
      s0 = n_soft;
      h0 = n_hard;
      wr(OFS_ALARM, {29'h0, 2'(i % 3), i < 3});
      ramp_pos <= 24'(lim);
      repeat (4) @(posedge clk);
      chk({31'h0, alarm_o}, 32'h0, "at limit");
      ramp_pos <= 24'(lim + 1);
      repeat (4) @(posedge clk);
      chk({31'h0, alarm_o}, 32'(i < 3), "deviation alarm");
      chk(n_soft - s0, 32'(i == 1), "soft stop");
      chk(n_hard - h0, 32'(i == 2), "hard stop");
      ramp_pos <= 24'h0;
      wr(OFS_STATUS, 32'h7);
    end
    $display("test deviation done");
    wr(OFS_ALARM, 32'h0);
    lim = $urandom_range(2, 3);
    tol = $urandom_range(2, 1000);
    wr(OFS_CORR, {tol[15:0], 8'h0, lim[7:0]});
    s0 = n_move;
    target_pos <= 24'(tol - 1);
    pulse_end(1'b0);
    repeat (8) @(posedge clk);
    chk(n_move - s0, 32'h0, "in tolerance");
    target_pos <= 24'(tol + 1);
    pulse_end(1'b0);
    for (int i = 0; i < 8 && alarm_o !== 1'b1; i++) begin
      repeat (20) if (corr_move_o !== 1'b1 && alarm_o !== 1'b1) @(posedge clk);
      if (corr_move_o === 1'b1) begin
        chk({31'h0, corr_up_o}, 32'h1, "correction direction");
        pulse_end(1'b1);
      end
    end
    chk({31'h0, alarm_o}, 32'h1, "retry alarm");
    chk(n_move - s0, 32'(lim), "retries");
    rd(OFS_STATUS, 32'h5, "status");
    $display("test ramp end correction done");
    wr(OFS_STATUS, 32'h7);
    target_pos <= 24'd100;
    wr(OFS_CORR, {16'd5, 8'h0, 8'h2});
    wr(OFS_DEVLIM, 32'h4);
    n = $urandom_range(1, 3);
    wr(OFS_ALARM, {n[15:0], 15'h0, 1'b1});
    ramp_pos <= 24'd5;
    t = 0;
    while (corr_move_o !== 1'b1 && t < 200) begin
      @(posedge clk);
      t++;
    end
    chk(32'(t >= n * TK && t <= n * TK + 6), 32'h1, "correction delay");
    chk({31'h0, alarm_o}, 32'h0, "alarm held off");
    target_pos <= 24'd0;
    pulse_end(1'b1);
    repeat (6) @(posedge clk);
    chk({31'h0, alarm_o | corr_move_o}, 32'h0, "corrected");
    $display("test delayed correction done");
    test_done();
  end
endmodule  // edm_monitor_bench
`default_nettype wire
